/* two_level_interrupt_controller.sv */
// Six-source, two-level interrupt controller with SFR port and CPU vector handshake
`timescale 1ns/1ps
`include "irq_ctrl_defines.svh"

module two_level_interrupt_controller #(
  parameter int NUM_SRC = 6
) (
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       clk_en_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       ext0_request_flag_i,
  input  wire logic       ext1_request_flag_i,
  input  wire logic       ext0_edge_mode_i,
  input  wire logic       ext1_edge_mode_i,
  input  wire logic       timer0_overflow_flag_i,
  input  wire logic       timer1_overflow_flag_i,
  input  wire logic       rx_done_flag_i,
  input  wire logic       tx_done_flag_i,
  input  wire logic       timer2_overflow_flag_i,
  input  wire logic       timer2_external_flag_i,
  output logic            ext0_flag_clr_o,
  output logic            ext1_flag_clr_o,
  output logic            timer0_flag_clr_o,
  output logic            timer1_flag_clr_o,
  output logic            vec_req_o,
  output logic      [7:0] vec_addr_o,
  input  wire logic       vec_ack_i,
  input  wire logic       reti_i,
  output logic      [1:0] in_service_o
);

  logic [7:0]                 interrupt_enable_register_r;
  logic [7:0]                 priority_level_register_r;
  logic [1:0]                 in_service_r;
  logic [NUM_SRC-1:0]         raw_req;
  logic [NUM_SRC-1:0]         enabled_req;
  irq_ctrl_pkg::grant_s       pick;
  irq_ctrl_pkg::grant_s       held_r;
  irq_ctrl_pkg::vec_state_e   state_r;
  logic                       global_irq_gate;
  logic                       may_grant;
  logic                       vec_taken;
  logic [1:0]                 in_service_nxt;

  // Request sources in polling order; index 0 is polled first
  assign raw_req = {timer2_overflow_flag_i | timer2_external_flag_i,
                    rx_done_flag_i | tx_done_flag_i,
                    timer1_overflow_flag_i,
                    ext1_request_flag_i,
                    timer0_overflow_flag_i,
                    ext0_request_flag_i};

  assign global_irq_gate = interrupt_enable_register_r[`IRQ_GATE_BIT];
  assign enabled_req = global_irq_gate ? (raw_req & interrupt_enable_register_r[5:0])
                                       : '0;

  function automatic logic [7:0] vector_of(input logic [2:0] s);
    case (s)
      3'h0:    vector_of = `VEC_EXT0;
      3'h1:    vector_of = `VEC_TIMER0;
      3'h2:    vector_of = `VEC_EXT1;
      3'h3:    vector_of = `VEC_TIMER1;
      3'h4:    vector_of = `VEC_SERIAL;
      default: vector_of = `VEC_TIMER2;
    endcase
  endfunction

  // Level 0 candidates first, then level 1 overrides them; lowest index wins inside a level
  always_comb
  begin
    pick = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (enabled_req[i] && !priority_level_register_r[i])
      begin
        pick.valid = 1'b1;
        pick.src   = 3'(i);
        pick.level = 1'b0;
      end
    end
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (enabled_req[i] && priority_level_register_r[i])
      begin
        pick.valid = 1'b1;
        pick.src   = 3'(i);
        pick.level = 1'b1;
      end
    end
  end

  // Level 1 needs nothing of level 1 in service; level 0 needs nothing at all
  assign may_grant = pick.valid &&
                     (pick.level ? !in_service_r[1] : (in_service_r == 2'b00));

  // Register port
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      interrupt_enable_register_r <= `IRQ_ENABLE_RESET;
      priority_level_register_r   <= `IRQ_PRIO_RESET;
    end
    else if (clk_en_i && sfr_wr_i)
    begin
      if (sfr_addr_i == `IRQ_ENABLE_ADDR)
        interrupt_enable_register_r <= sfr_wdata_i & 8'hBF;
      if (sfr_addr_i == `IRQ_PRIORITY_ADDR)
        priority_level_register_r <= sfr_wdata_i & `IRQ_SRC_MASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sfr_rdata_o <= 8'h00;
    else if (clk_en_i)
    begin
      case (sfr_addr_i)
        `IRQ_ENABLE_ADDR:   sfr_rdata_o <= interrupt_enable_register_r;
        `IRQ_PRIORITY_ADDR: sfr_rdata_o <= priority_level_register_r;
        default:            sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // Vector handshake; the grant is frozen while the core has not yet taken it
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r    <= irq_ctrl_pkg::ST_IDLE;
      held_r     <= '0;
      vec_req_o  <= 1'b0;
      vec_addr_o <= 8'h00;
    end
    else if (clk_en_i)
    begin
      case (state_r)
        irq_ctrl_pkg::ST_IDLE:
          if (may_grant)
          begin
            state_r    <= irq_ctrl_pkg::ST_REQ;
            held_r     <= pick;
            vec_req_o  <= 1'b1;
            vec_addr_o <= vector_of(pick.src);
          end
        irq_ctrl_pkg::ST_REQ:
          if (vec_ack_i)
          begin
            state_r   <= irq_ctrl_pkg::ST_IDLE;
            vec_req_o <= 1'b0;
          end
        default:
          state_r <= irq_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // The core takes the vector on the edge where it acknowledges the standing request
  assign vec_taken = (state_r == irq_ctrl_pkg::ST_REQ) && vec_ack_i;

  // Two in-service bits; a return retires the highest active level before a take marks
  // the new one, so a return and a take in one cycle leave the taken level in service
  always_comb
  begin
    in_service_nxt = in_service_r;
    if (reti_i)
    begin
      if (in_service_r[1])
        in_service_nxt[1] = 1'b0;
      else
        in_service_nxt[0] = 1'b0;
    end
    if (vec_taken)
      in_service_nxt[held_r.level] = 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      in_service_r <= 2'b00;
    else if (clk_en_i)
      in_service_r <= in_service_nxt;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      in_service_o <= 2'b00;
    else if (clk_en_i)
      in_service_o <= in_service_r;
  end

  // Flag clears are one-cycle pulses issued when the core takes the vector, for ext0/ext1 only in
  // edge mode; serial and timer 2 flags get no pulse, they stay set until firmware drops them
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ext0_flag_clr_o   <= 1'b0;
      ext1_flag_clr_o   <= 1'b0;
      timer0_flag_clr_o <= 1'b0;
      timer1_flag_clr_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      ext0_flag_clr_o   <= vec_taken && held_r.src == 3'h0 && ext0_edge_mode_i;
      timer0_flag_clr_o <= vec_taken && held_r.src == 3'h1;
      ext1_flag_clr_o   <= vec_taken && held_r.src == 3'h2 && ext1_edge_mode_i;
      timer1_flag_clr_o <= vec_taken && held_r.src == 3'h3;
    end
  end

  AST_GATE_BLOCKS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (clk_en_i && state_r == irq_ctrl_pkg::ST_IDLE && !global_irq_gate) |=> !vec_req_o)
    else $error("vector raised with global gate low");
  AST_NO_SAME_LEVEL: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(vec_req_o) |-> !(held_r.level ? in_service_r[1] : in_service_r[0]))
    else $error("grant during same-level service");
  AST_PREEMPT: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (clk_en_i && state_r == irq_ctrl_pkg::ST_IDLE && in_service_r == 2'b01 && pick.valid
     && pick.level) |=> vec_req_o)
    else $error("level 1 did not preempt level 0");
  AST_VECTOR_MAP: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    vec_req_o |-> vec_addr_o == {2'b00, held_r.src, 3'b011})
    else $error("vector address mismatch");
  AST_TIMER0_CLR: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(timer0_flag_clr_o) |-> $past(held_r.src) == 3'h1)
    else $error("timer0 clear on wrong source");
  AST_LEVEL_PICK: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (pick.valid && !pick.level) |-> (enabled_req & priority_level_register_r[5:0]) == 6'h00)
    else $error("level 0 picked over pending level 1");
  AST_POLL_ORDER: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (pick.valid && pick.src != 3'h0) |-> !(enabled_req[0] &&
     priority_level_register_r[0] == pick.level))
    else $error("polling order broken");
  AST_RESUME: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (clk_en_i && in_service_r == 2'b11 && reti_i && !vec_ack_i) |=> in_service_r == 2'b01)
    else $error("level 0 lost on return from level 1");
  AST_BIT6_ZERO: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !interrupt_enable_register_r[6] && priority_level_register_r[7:6] == 2'b00)
    else $error("unimplemented bit set");

  // Vector handshake, in-service and grant checks
  AST_REQ_HOLDS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (vec_req_o && !vec_ack_i) |=> (vec_req_o && $stable(vec_addr_o)))
    else $error("vector request dropped before acknowledge");
  AST_ACK_DROPS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (clk_en_i && vec_req_o && vec_ack_i) |=> !vec_req_o)
    else $error("vector request stayed after acknowledge");
  AST_ACK_MARKS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (clk_en_i && vec_taken) |=> in_service_r[held_r.level])
    else $error("taken level not marked in service");
  AST_STATUS_COPY: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    clk_en_i |=> in_service_o == $past(in_service_r))
    else $error("in-service output does not follow state");
  AST_GRANT_IDLE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (clk_en_i && state_r == irq_ctrl_pkg::ST_IDLE && in_service_r == 2'b00 && pick.valid)
    |=> vec_req_o)
    else $error("pending request not granted while idle");
  AST_LEVEL1_BLOCKS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (clk_en_i && state_r == irq_ctrl_pkg::ST_IDLE && in_service_r[1]) |=> !vec_req_o)
    else $error("grant while level 1 in service");

  // Grant source and flag-clear checks
  AST_NO_PICK_IDLE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (clk_en_i && state_r == irq_ctrl_pkg::ST_IDLE && !pick.valid) |=> !vec_req_o)
    else $error("vector raised with nothing pending");
  AST_PICK_ENABLED: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    pick.valid |-> enabled_req[pick.src])
    else $error("picked source is not an enabled request");
  AST_TIMER1_CLR: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(timer1_flag_clr_o) |-> $past(held_r.src) == 3'h3)
    else $error("timer1 clear on wrong source");
  AST_EXT0_CLR: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(ext0_flag_clr_o) |-> ($past(held_r.src) == 3'h0 && $past(ext0_edge_mode_i)))
    else $error("ext0 clear on wrong source or mode");
  AST_EXT1_LEVEL_KEEP: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (clk_en_i && !ext1_edge_mode_i) |=> !ext1_flag_clr_o)
    else $error("ext1 cleared in level mode");
  AST_CLR_ONE_HOT: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $onehot0({ext0_flag_clr_o, ext1_flag_clr_o, timer0_flag_clr_o, timer1_flag_clr_o}))
    else $error("more than one flag clear at once");

endmodule

/* irq_ctrl_defines.svh */
// Register addresses, bit positions, reset values and vectors of the interrupt controller
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH
`define IRQ_ENABLE_ADDR   8'hA8
`define IRQ_PRIORITY_ADDR 8'hB8
`define IRQ_GATE_BIT      7
`define IRQ_SRC_MASK      8'h3F
`define IRQ_ENABLE_RESET  8'h00
`define IRQ_PRIO_RESET    8'h00
`define VEC_EXT0          8'h03
`define VEC_TIMER0        8'h0B
`define VEC_EXT1          8'h13
`define VEC_TIMER1        8'h1B
`define VEC_SERIAL        8'h23
`define VEC_TIMER2        8'h2B
`endif

/* irq_ctrl_pkg.sv */
// Types shared by the interrupt controller
package irq_ctrl_pkg;
  typedef struct packed {
    logic       valid;
    logic [2:0] src;
    logic       level;
  } grant_s;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ} vec_state_e;
endpackage

/* core_model.sv */
// Behavioural CPU core that takes vectors from the interrupt controller
`timescale 1ns/1ps
module core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       vec_req_i,
  input  wire logic [7:0] vec_addr_i,
  input  wire logic [3:0] dly_i,
  output logic            vec_ack_o,
  output logic      [7:0] last_vec_o,
  output int              ack_cnt_o
);
  logic [3:0] wait_r;
  // Ack is held until seen with the request; dly_i stalls it to act as a slow core
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      vec_ack_o  <= 1'b0;
      last_vec_o <= 8'h00;
      ack_cnt_o  <= 0;
      wait_r     <= 4'h0;
    end
    else if (vec_ack_o && vec_req_i)
    begin
      vec_ack_o  <= 1'b0;
      last_vec_o <= vec_addr_i;
      ack_cnt_o  <= ack_cnt_o + 1;
      wait_r     <= 4'h0;
    end
    else if (vec_req_i && wait_r >= dly_i)
      vec_ack_o <= 1'b1;
    else if (vec_req_i)
      wait_r <= wait_r + 4'h1;
  end
endmodule

/* two_level_interrupt_controller_tb.sv */
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
`include "irq_ctrl_defines.svh"
module two_level_interrupt_controller_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] flg = 8'h00;
  logic [3:0] clr;
  logic       vreq;
  logic [7:0] vaddr;
  logic       ack;
  logic       reti = 1'b0;
  logic [1:0] ins;
  logic [3:0] dly = 4'h0;
  logic [7:0] last_vec;
  int         ack_cnt;
  int         seen = 0;
  int         fail_count = 0;
  int         cmp_count = 0;
  int         clr_cnt [4] = '{0, 0, 0, 0};
  logic [7:0] vecs [6] = '{`VEC_EXT0, `VEC_TIMER0, `VEC_EXT1, `VEC_TIMER1, `VEC_SERIAL,
                           `VEC_TIMER2};
  logic [7:0] masks [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h30, 8'hC0};
  always #5 clk = ~clk;
  // Flag bits: ext0, timer0, ext1, timer1, rx, tx, timer2 overflow, timer2 external
  two_level_interrupt_controller two_level_interrupt_controller_inst (
    .core_clk_i(clk), .arst_n_i(rst_n), .clk_en_i(1'b1), .sfr_wr_i(wr), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .ext0_request_flag_i(flg[0]),
    .ext1_request_flag_i(flg[2]), .ext0_edge_mode_i(1'b1), .ext1_edge_mode_i(1'b0),
    .timer0_overflow_flag_i(flg[1]), .timer1_overflow_flag_i(flg[3]),
    .rx_done_flag_i(flg[4]), .tx_done_flag_i(flg[5]), .timer2_overflow_flag_i(flg[6]),
    .timer2_external_flag_i(flg[7]), .ext0_flag_clr_o(clr[0]), .ext1_flag_clr_o(clr[1]),
    .timer0_flag_clr_o(clr[2]), .timer1_flag_clr_o(clr[3]), .vec_req_o(vreq),
    .vec_addr_o(vaddr), .vec_ack_i(ack), .reti_i(reti), .in_service_o(ins));
  core_model core_model_inst (.clk_i(clk), .rst_n_i(rst_n), .vec_req_i(vreq),
    .vec_addr_i(vaddr), .dly_i(dly), .vec_ack_o(ack), .last_vec_o(last_vec),
    .ack_cnt_o(ack_cnt));
  always @(posedge clk)
    for (int k = 0; k < 4; k++)
      if (clr[k] === 1'b1)
        clr_cnt[k]++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    #1 chk(rdata, exp);
  endtask
  task automatic take_vec(input logic [7:0] exp, input logic [1:0] exp_ins);
    int n;
    n = 0;
    while (ack_cnt <= seen && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, ack_cnt > seen}, 8'h01);
    seen++;
    repeat (3) @(posedge clk);
    #1 chk(last_vec, exp);
    chk({6'h00, ins}, {6'h00, exp_ins});
  endtask
  task automatic ret(input logic [1:0] exp_ins);
    @(posedge clk);
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({6'h00, ins}, {6'h00, exp_ins});
  endtask
  task automatic idle_chk();
    repeat (12) @(posedge clk);
    #1 chk({7'h00, vreq}, 8'h00);
    chk(8'(ack_cnt), 8'(seen));
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #200000;
    fail_count++;
    wrap_up();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    sfr_rd(`IRQ_ENABLE_ADDR, `IRQ_ENABLE_RESET);
    sfr_rd(`IRQ_PRIORITY_ADDR, `IRQ_PRIO_RESET);
    sfr_wr(`IRQ_ENABLE_ADDR, 8'hFF);
    sfr_rd(`IRQ_ENABLE_ADDR, 8'hBF);
    sfr_wr(`IRQ_PRIORITY_ADDR, 8'hFF);
    sfr_rd(`IRQ_PRIORITY_ADDR, 8'h3F);
    sfr_rd(8'h90, 8'h00);
    $display("test registers done");
    sfr_wr(`IRQ_PRIORITY_ADDR, 8'h00);
    sfr_wr(`IRQ_ENABLE_ADDR, 8'h3F);
    flg <= 8'hAF;
    idle_chk();
    sfr_wr(`IRQ_ENABLE_ADDR, 8'hBF);
    // Serial and timer 2 ride on tx and external flags alone
    for (int i = 0; i < 6; i++)
    begin
      take_vec(vecs[i], 2'b01);
      @(posedge clk);
      flg <= flg & ~masks[i];
      ret(2'b00);
    end
    chk(8'(clr_cnt[0] * 64 + clr_cnt[1] * 16 + clr_cnt[2] * 4 + clr_cnt[3]), 8'h45);
    $display("test polling order done");
    @(posedge clk);
    dly <= 4'h3;
    sfr_wr(`IRQ_PRIORITY_ADDR, 8'h02);
    flg <= 8'h04;
    take_vec(`VEC_EXT1, 2'b01);
    @(posedge clk);
    flg <= 8'h05;
    idle_chk();
    @(posedge clk);
    flg <= 8'h07;
    take_vec(`VEC_TIMER0, 2'b11);
    @(posedge clk);
    flg <= 8'h01;
    ret(2'b01);
    idle_chk();
    ret(2'b00);
    take_vec(`VEC_EXT0, 2'b01);
    @(posedge clk);
    flg <= 8'h00;
    ret(2'b00);
    $display("test nesting done");
    wrap_up();
  end
endmodule
